// >>> rtl/lce_pkg.sv
// shared constants of the lookup command executor
package lce_pkg;
   localparam int AXI_AW = 6;
   localparam int NUM_PARAM_WORDS = 10;
   localparam logic [3:0] IDX_CMD_LO = 4'h0;
   localparam logic [3:0] IDX_CMD_HI = 4'h1;
   localparam logic [3:0] IDX_D0_LO = 4'h2;
   localparam logic [3:0] IDX_RES0_LO = 4'hA;
   localparam logic [3:0] IDX_RES0_HI = 4'hB;
   localparam logic [3:0] IDX_RES1_LO = 4'hC;
   localparam logic [3:0] IDX_RES1_HI = 4'hD;
   localparam logic [3:0] IDX_ERR = 4'hE;
   localparam logic [3:0] IDX_UNMAPPED = 4'hF;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_LAYER_LSB = 8;
   localparam int CMD_SIZE_LSB = 25;
   localparam int CMD_LOC_LSB = 27;
   localparam int CMD_START_BIT = 31;
   localparam int CMD_PROC_LSB = 32;
   localparam int CMD_CTX_LSB = 40;
   localparam int CMD_CMP_LSB = 48;
   localparam int CMP_W = 3;
   // parameter word 0 fields
   localparam int D0_ADDR_LSB = 0;
   localparam int D0_SEL_LSB = 19;
   localparam int D0_ADDR2_LSB = 24;
   localparam int D0_SEL2_LSB = 43;
   localparam int D0_LEN_LSB = 48;
   localparam int ADDR_W = 16;
   localparam int SEL_W = 5;
   localparam int LEN_W = 9;
   localparam int ID_W = 5;
   localparam int ENG_W = 68;
   // completion status word fields
   localparam int RES_LOW_LSB = 0;
   localparam int RES_CTX_LSB = 24;
   localparam int RES_ERR_BIT = 29;
   localparam int RES_DONE_BIT = 31;
   localparam int RES_PROC_LSB = 32;
   localparam int ERR_LEARN_BIT = 0;
   localparam int ERR_CMD_BIT = 1;
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_SEARCH = 3'h2;
   localparam logic [2:0] OP_LEARN = 3'h3;
   localparam logic [2:0] OP_MOVE = 3'h4;
   localparam logic [2:0] OP_SWAP = 3'h5;
   localparam logic [1:0] LOC_SSRAM = 2'h2;
   localparam logic [1:0] SIZE_X68 = 2'h0;
   localparam logic [1:0] SIZE_X136 = 2'h1;
   localparam logic [1:0] SIZE_X272 = 2'h2;
   localparam logic [1:0] SIZE_RSVD = 2'h3;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// >>> rtl/lce_buf_if.sv
// port between sequencer and burst staging buffer
`timescale 1ns/100ps
`default_nettype none
interface lce_buf_if #(
   parameter int W = 68,
   parameter int DEPTH = 256
);
   localparam int IW = $clog2(DEPTH);
   logic wrEn;
   logic [IW-1:0] wrIdx;
   logic [IW-1:0] rdIdx;
   logic [W-1:0] wrData;
   logic [W-1:0] rdData;
   modport ctl (output wrEn, wrIdx, rdIdx, wrData, input rdData);
   modport mem (input wrEn, wrIdx, rdIdx, wrData, output rdData);
endinterface
`default_nettype wire

// >>> rtl/lce_burst_buf.sv
// staging buffer for move and swap bursts
`timescale 1ns/100ps
`default_nettype none
module lce_burst_buf #(
   parameter int W = 68,
   parameter int DEPTH = 256
)
(
   input wire logic sys_clk,
   lce_buf_if.mem port
);
   import lce_pkg::*;
   logic [W-1:0] memQ [DEPTH];

   if (DEPTH < 4)
      $error("buffer depth too small");

   // contents need no reset: every entry is written before it is read
   always_ff @(posedge sys_clk)
   begin
      if (port.wrEn)
         memQ[port.wrIdx] <= port.wrData;
   end

   assign port.rdData = memQ[port.rdIdx];
endmodule
`default_nettype wire

// >>> rtl/lce_executor.sv
// lookup command executor: registers, sequencer and engine bus driver
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1: search drives engine bits 3..0 from the command word layer nibbles.
// RULE2: size 00 puts word 0 on bits 67..4 in both cycles.
// RULE3: size 01 puts word 0 then word 1 on bits 67..4.
// RULE4: size 10 puts words 0 to 3 in four cycles; 11 reserved.
// RULE5: learn uses comparand index from command word and word 0 value.
// RULE6: learn while table full fails, sets result error and learn error.
// RULE7: move word 0: source addr, source select, dest addr, dest select, length.
// RULE8: software keeps move length between 4 and 256 entries.
// RULE9: move is a burst read, then a burst write.
// RULE10: swap word 0: first addr/select, second addr/select, length.
// RULE11: software keeps swap length between 4 and 128 entries.
// RULE12: swap is two burst reads, then two burst writes.
// RULE13: software keeps move and swap inside one engine chip.
// RULE14: memory access: addr 15..0, select 23..19, word 1 write data.
// RULE15: engine writes take bits 67..4 from word 1, 3..0 from layer; the code takes 3..0 from command bits 15..12.
// RULE16: status word: proc id 36..32, done 31, ctx id 28..24, data 3..0.
// RULE17: proc and context ids are copied from the command word.
// RULE18: reading the status word clears done.
// RULE19: software writes a new command only after done is set.
// RULE20: low data nibble only valid for engine reads, not memory reads.
// RULE21: data word holds engine bits 67..4 or the 64-bit memory word.
// RULE22: write, move, swap, learn results use the status word only.
// RULE23: search size code sits in command bits 26..25.
// RULE24: layer fields: 11..8 for x68, 15..8 for x136, 23..8 for x272.
// RULE25: reserved result bits read as zero.
module lce_executor #(
   parameter int BUF_DEPTH = 256
)
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [lce_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [lce_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic engValid,
   output logic [2:0] engOp,
   output logic [1:0] engLoc,
   output logic [lce_pkg::SEL_W-1:0] engSelectId,
   output logic [lce_pkg::ADDR_W-1:0] engAddr,
   output logic [lce_pkg::ENG_W-1:0] engDq,
   input wire logic engReadValid,
   input wire logic [lce_pkg::ENG_W-1:0] engineReadData,
   input wire logic tableFullFlag
);
   import lce_pkg::*;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SEARCH, ST_LEARN, ST_ISSUE, ST_COLLECT, ST_FINISH
   } lce_state_e;
   localparam int IW = $clog2(BUF_DEPTH);

   if (BUF_DEPTH < 256 || BUF_DEPTH > 512)
      $error("staging buffer must hold 256 to 512 entries");

   logic [31:0] parQ [NUM_PARAM_WORDS];
   lce_state_e stQ;
   logic [1:0] passQ;
   logic [LEN_W-1:0] idxQ;
   logic [LEN_W-1:0] rcntQ;
   logic doneQ;
   logic resErrQ;
   logic [3:0] resLowQ;
   logic [63:0] res1Q;
   logic [1:0] errStQ;
   logic [ID_W-1:0] procQ;
   logic [ID_W-1:0] ctxQ;
   logic awHeldQ;
   logic wHeldQ;
   logic bvalidQ;
   logic rvalidQ;
   logic [3:0] awIdxQ;
   logic [31:0] wDataQ;
   logic [3:0] wStrbQ;
   logic [1:0] brespQ;
   logic [1:0] rrespQ;
   logic [31:0] rdataQ;
   logic engValidQ;
   logic [2:0] engOpQ;
   logic [1:0] engLocQ;
   logic [SEL_W-1:0] engSelQ;
   logic [ADDR_W-1:0] engAddrQ;
   logic [ENG_W-1:0] engDqQ;
   logic [1:0] outIdxQ;
   logic [ENG_W+1:0] syncAQ;
   logic [ENG_W+1:0] syncBQ;

   // pin inputs: two flops before use
   always_ff @(posedge sys_clk)
   begin
      syncAQ <= {tableFullFlag, engReadValid, engineReadData};
      syncBQ <= syncAQ;
   end

   logic fullS;
   logic rdValidS;
   logic [ENG_W-1:0] rdDataS;
   assign fullS = syncBQ[ENG_W+1];
   assign rdValidS = syncBQ[ENG_W];
   assign rdDataS = syncBQ[ENG_W-1:0];

   // descriptor fields
   logic [63:0] cmdW;
   logic [63:0] dW [4];
   assign cmdW = {parQ[IDX_CMD_HI], parQ[IDX_CMD_LO]};
   for (genvar k = 0; k < 4; k++)
   begin : g_words
      assign dW[k] = {parQ[IDX_D0_LO + 2*k + 1], parQ[IDX_D0_LO + 2*k]};
   end

   logic [2:0] opW;
   logic [1:0] sizeW;
   logic [1:0] locW;
   logic [ID_W-1:0] procW;
   logic [ID_W-1:0] ctxW;
   logic [ADDR_W-1:0] addr1W;
   logic [ADDR_W-1:0] addr2W;
   logic [SEL_W-1:0] sel1W;
   logic [SEL_W-1:0] sel2W;
   logic [LEN_W-1:0] lenW;
   assign opW = cmdW[CMD_OP_LSB +: 3];
   assign sizeW = cmdW[CMD_SIZE_LSB +: 2]; // RULE23
   assign locW = cmdW[CMD_LOC_LSB +: 2];
   assign procW = cmdW[CMD_PROC_LSB +: ID_W];
   assign ctxW = cmdW[CMD_CTX_LSB +: ID_W];
   assign addr1W = dW[0][D0_ADDR_LSB +: ADDR_W]; // RULE7 RULE10 RULE14
   assign sel1W = dW[0][D0_SEL_LSB +: SEL_W]; // RULE14
   assign addr2W = dW[0][D0_ADDR2_LSB +: ADDR_W]; // RULE7 RULE10
   assign sel2W = dW[0][D0_SEL2_LSB +: SEL_W]; // RULE7 RULE10
   assign lenW = dW[0][D0_LEN_LSB +: LEN_W]; // RULE7 RULE10

   // pass plan: move = read, write; swap = read, read, write, write
   logic isBlock;
   logic isSwap;
   logic passRead;
   logic useSecond;
   logic lastPass;
   logic [LEN_W-1:0] passCnt;
   logic [LEN_W-1:0] bufBase;
   logic [ADDR_W-1:0] passAddr;
   logic [SEL_W-1:0] passSel;
   assign isSwap = opW == OP_SWAP;
   assign isBlock = isSwap || opW == OP_MOVE;
   assign passRead = opW == OP_READ ||
      (isBlock && (passQ == 2'h0 || (isSwap && passQ == 2'h1))); // RULE9 RULE12
   assign useSecond = isBlock && passQ[0];
   assign lastPass = isSwap ? passQ == 2'h3 :
      (opW == OP_MOVE ? passQ == 2'h1 : 1'b1);
   assign passCnt = isBlock ? lenW : 9'h001;
   // swap keeps the second region above the first in the buffer
   assign bufBase = (isSwap && (passQ == 2'h1 || passQ == 2'h2)) ?
      lenW : 9'h000;
   assign passAddr = (useSecond ? addr2W : addr1W) + ADDR_W'(idxQ);
   assign passSel = useSecond ? sel2W : sel1W;

   lce_buf_if #(.W(ENG_W), .DEPTH(BUF_DEPTH)) bufIf ();
   lce_burst_buf #(.W(ENG_W), .DEPTH(BUF_DEPTH)) u_buf (
      .sys_clk(sys_clk),
      .port(bufIf)
   );
   assign bufIf.wrEn = stQ == ST_COLLECT && rdValidS && isBlock;
   assign bufIf.wrIdx = IW'(bufBase + rcntQ);
   assign bufIf.rdIdx = IW'(bufBase + idxQ);
   assign bufIf.wrData = rdDataS;

   // engine data for the current cycle
   logic [1:0] beat;
   logic [LEN_W-1:0] lastBeat;
   logic [3:0] beatLayer;
   logic [63:0] beatWord;
   logic [ENG_W-1:0] engDqD;
   assign beat = idxQ[1:0];
   assign lastBeat = sizeW == SIZE_X272 ? 9'h003 : 9'h001; // RULE4
   assign beatWord = sizeW == SIZE_X68 ? dW[0] : dW[beat]; // RULE2 RULE3 RULE4
   assign beatLayer = sizeW == SIZE_X68 ? cmdW[CMD_LAYER_LSB +: 4] :
      cmdW[CMD_LAYER_LSB + 4*beat +: 4]; // RULE1 RULE24
   always_comb
   begin
      engDqD = '0;
      case (stQ)
         ST_SEARCH: engDqD = {beatWord, beatLayer}; // RULE1
         ST_LEARN: engDqD = {dW[0], 4'h0}; // RULE5
         ST_ISSUE:
            if (!isBlock)
               engDqD = {dW[1], cmdW[CMD_LAYER_LSB + 4 +: 4]}; // RULE15
            else if (!passRead)
               engDqD = bufIf.rdData;
         default: engDqD = '0;
      endcase
   end

   // register bus decode
   logic doWrite;
   logic startReq;
   logic busy;
   logic [3:0] arIdx;
   logic rdRes0Hs;
   logic [31:0] mergedW;
   lce_state_e startSt;
   assign busy = stQ != ST_IDLE;
   assign doWrite = awHeldQ && wHeldQ && !bvalidQ;
   assign startReq = doWrite && awIdxQ == IDX_CMD_LO && wStrbQ[3] &&
      wDataQ[CMD_START_BIT] && !busy;
   assign arIdx = s_axi_araddr[5:2];
   assign rdRes0Hs = s_axi_arvalid && !rvalidQ && arIdx == IDX_RES0_LO;
   for (genvar b = 0; b < 4; b++)
   begin : g_merge
      assign mergedW[8*b +: 8] = wStrbQ[b] ? wDataQ[8*b +: 8] :
         (awIdxQ < 4'hA ? parQ[awIdxQ][8*b +: 8] : 8'h00);
   end
   always_comb
   begin
      case (wDataQ[CMD_OP_LSB +: 3])
         OP_SEARCH:
            startSt = wDataQ[CMD_SIZE_LSB +: 2] == SIZE_RSVD ?
               ST_FINISH : ST_SEARCH;
         OP_LEARN: startSt = ST_LEARN;
         OP_READ, OP_WRITE, OP_MOVE, OP_SWAP: startSt = ST_ISSUE;
         default: startSt = ST_FINISH;
      endcase
   end

   // parameter words refuse writes while a command runs
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         for (int i = 0; i < NUM_PARAM_WORDS; i++)
            parQ[i] <= REG_RST;
      else if (doWrite && !busy && awIdxQ < 4'hA)
         parQ[awIdxQ] <= mergedW;
   end

   // sequencer
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         stQ <= ST_IDLE;
         passQ <= 2'h0;
         idxQ <= '0;
         rcntQ <= '0;
      end
      else
      begin
         case (stQ)
            ST_IDLE:
               if (startReq)
               begin
                  passQ <= 2'h0;
                  idxQ <= '0;
                  rcntQ <= '0;
                  stQ <= startSt;
               end
            ST_SEARCH:
               if (idxQ == lastBeat)
                  stQ <= ST_FINISH;
               else
                  idxQ <= idxQ + 9'h001;
            ST_LEARN: stQ <= ST_FINISH;
            ST_ISSUE:
               if (idxQ == passCnt - 9'h001)
               begin
                  idxQ <= '0;
                  if (passRead)
                     stQ <= ST_COLLECT;
                  else if (lastPass)
                     stQ <= ST_FINISH;
                  else
                     passQ <= passQ + 2'h1;
               end
               else
                  idxQ <= idxQ + 9'h001;
            ST_COLLECT:
               if (rdValidS)
               begin
                  rcntQ <= rcntQ + 9'h001;
                  if (rcntQ == passCnt - 9'h001)
                  begin
                     rcntQ <= '0;
                     if (lastPass)
                        stQ <= ST_FINISH;
                     else
                     begin
                        passQ <= passQ + 2'h1;
                        stQ <= ST_ISSUE;
                     end
                  end
               end
            ST_FINISH: stQ <= ST_IDLE;
            default: stQ <= ST_IDLE;
         endcase
      end
   end

   // engine bus outputs
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         engValidQ <= 1'b0;
         engOpQ <= OP_READ;
         engLocQ <= 2'h0;
         engSelQ <= '0;
         engAddrQ <= '0;
         engDqQ <= '0;
         outIdxQ <= 2'h0;
      end
      else
      begin
         engValidQ <= stQ == ST_SEARCH || stQ == ST_ISSUE ||
            (stQ == ST_LEARN && !fullS); // RULE6
         engOpQ <= stQ == ST_SEARCH ? OP_SEARCH :
            (stQ == ST_LEARN ? OP_LEARN :
            (passRead ? OP_READ : OP_WRITE)); // RULE9 RULE12
         engLocQ <= locW;
         engSelQ <= stQ == ST_ISSUE ? passSel : sel1W;
         engAddrQ <= stQ == ST_LEARN ?
            ADDR_W'(cmdW[CMD_CMP_LSB +: CMP_W]) : passAddr; // RULE5
         engDqQ <= engDqD;
         outIdxQ <= beat;
      end
   end

   // completion words
   logic sizeErr;
   logic learnFail;
   logic [63:0] res0W;
   assign sizeErr = (opW == OP_SEARCH && sizeW == SIZE_RSVD) ||
      opW > OP_SWAP; // RULE4
   assign learnFail = stQ == ST_LEARN && fullS; // RULE6
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         doneQ <= 1'b0;
         resErrQ <= 1'b0;
         resLowQ <= 4'h0;
         res1Q <= '0;
         procQ <= '0;
         ctxQ <= '0;
      end
      else
      begin
         if (startReq)
         begin
            procQ <= procW; // RULE17
            ctxQ <= ctxW; // RULE17
            resErrQ <= 1'b0;
            resLowQ <= 4'h0;
            res1Q <= '0; // RULE22
         end
         if (learnFail || (stQ == ST_FINISH && sizeErr))
            resErrQ <= 1'b1; // RULE6
         if (stQ == ST_COLLECT && rdValidS && opW == OP_READ)
         begin
            if (locW == LOC_SSRAM)
            begin
               res1Q <= rdDataS[63:0]; // RULE21
               resLowQ <= 4'h0; // RULE20
            end
            else
            begin
               res1Q <= rdDataS[ENG_W-1:4]; // RULE21
               resLowQ <= rdDataS[3:0]; // RULE16
            end
         end
         // completion beats a clear in the same cycle
         if (stQ == ST_FINISH)
            doneQ <= 1'b1;
         else if (rdRes0Hs)
            doneQ <= 1'b0; // RULE18
      end
   end

   always_comb
   begin
      res0W = '0; // RULE25
      res0W[RES_DONE_BIT] = doneQ; // RULE16
      res0W[RES_ERR_BIT] = resErrQ;
      res0W[RES_CTX_LSB +: ID_W] = ctxQ; // RULE16
      res0W[RES_PROC_LSB +: ID_W] = procQ; // RULE16
      res0W[RES_LOW_LSB +: 4] = resLowQ;
   end

   // error status: sticky, write one to clear, set wins
   logic [1:0] errSet;
   logic [1:0] errClr;
   assign errSet = {stQ == ST_FINISH && sizeErr, learnFail};
   assign errClr = (doWrite && awIdxQ == IDX_ERR && wStrbQ[0]) ?
      wDataQ[1:0] : 2'h0;
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         errStQ <= 2'h0;
      else
         errStQ <= (errStQ & ~errClr) | errSet; // RULE6
   end

   logic [31:0] rdMux;
   always_comb
   begin
      case (arIdx)
         IDX_CMD_LO: rdMux = {busy, parQ[IDX_CMD_LO][30:0]};
         IDX_RES0_LO: rdMux = res0W[31:0];
         IDX_RES0_HI: rdMux = res0W[63:32];
         IDX_RES1_LO: rdMux = res1Q[31:0];
         IDX_RES1_HI: rdMux = res1Q[63:32];
         IDX_ERR: rdMux = {30'h0, errStQ};
         IDX_UNMAPPED: rdMux = REG_RST;
         default: rdMux = parQ[arIdx];
      endcase
   end

   // AXI4-Lite slave handshakes
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         awHeldQ <= 1'b0;
         wHeldQ <= 1'b0;
         bvalidQ <= 1'b0;
         rvalidQ <= 1'b0;
         awIdxQ <= 4'h0;
         wDataQ <= REG_RST;
         wStrbQ <= 4'h0;
         brespQ <= AXI_OKAY;
         rrespQ <= AXI_OKAY;
         rdataQ <= REG_RST;
      end
      else
      begin
         if (s_axi_awvalid && !awHeldQ)
         begin
            awHeldQ <= 1'b1;
            awIdxQ <= s_axi_awaddr[5:2];
         end
         else if (doWrite)
            awHeldQ <= 1'b0;
         if (s_axi_wvalid && !wHeldQ)
         begin
            wHeldQ <= 1'b1;
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
         end
         else if (doWrite)
            wHeldQ <= 1'b0;
         if (doWrite)
         begin
            bvalidQ <= 1'b1;
            brespQ <= awIdxQ == IDX_UNMAPPED ? AXI_SLVERR : AXI_OKAY;
         end
         else if (s_axi_bready)
            bvalidQ <= 1'b0;
         if (s_axi_arvalid && !rvalidQ)
         begin
            rvalidQ <= 1'b1;
            rdataQ <= rdMux;
            rrespQ <= arIdx == IDX_UNMAPPED ? AXI_SLVERR : AXI_OKAY;
         end
         else if (s_axi_rready)
            rvalidQ <= 1'b0;
      end
   end

   assign s_axi_awready = !awHeldQ;
   assign s_axi_wready = !wHeldQ;
   assign s_axi_bvalid = bvalidQ;
   assign s_axi_bresp = brespQ;
   assign s_axi_arready = !rvalidQ;
   assign s_axi_rvalid = rvalidQ;
   assign s_axi_rdata = rdataQ;
   assign s_axi_rresp = rrespQ;
   assign engValid = engValidQ;
   assign engOp = engOpQ;
   assign engLoc = engLocQ;
   assign engSelectId = engSelQ;
   assign engAddr = engAddrQ;
   assign engDq = engDqQ;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_search_low_nibble: assert property ( // RULE1
      engValidQ && engOpQ == OP_SEARCH && outIdxQ == 2'h0 |->
      engDqQ[3:0] == cmdW[CMD_LAYER_LSB +: 4])
      else $error("search nibble not from layer field");
   a_search_x68_key: assert property ( // RULE2
      engValidQ && engOpQ == OP_SEARCH && outIdxQ == 2'h0 &&
      sizeW == SIZE_X68 |-> engDqQ[67:4] == dW[0] ##1
      engValidQ && engDqQ[67:4] == dW[0] && !$stable(outIdxQ))
      else $error("x68 key not repeated in two cycles");
   a_search_x136_key: assert property ( // RULE3
      engValidQ && engOpQ == OP_SEARCH && outIdxQ == 2'h0 &&
      sizeW == SIZE_X136 |-> engDqQ[67:4] == dW[0] ##1
      engDqQ[67:4] == dW[1] && engDqQ[3:0] == cmdW[12 +: 4])
      else $error("x136 key order wrong");
   a_search_x272_key: assert property ( // RULE4
      engValidQ && engOpQ == OP_SEARCH && outIdxQ == 2'h0 &&
      sizeW == SIZE_X272 |-> ##3 engValidQ &&
      engDqQ[67:4] == dW[3] ##1 !engValidQ)
      else $error("x272 key not four cycles");
   a_learn_full_fail: assert property ( // RULE6
      learnFail |=> !engValidQ && resErrQ && errStQ[ERR_LEARN_BIT])
      else $error("learn on full table not failed");
   a_move_write_order: assert property ( // RULE9
      engValidQ && opW == OP_MOVE && engOpQ == OP_WRITE |->
      passQ == 2'h1)
      else $error("move write before read pass");
   a_swap_write_order: assert property ( // RULE12
      engValidQ && opW == OP_SWAP && engOpQ == OP_WRITE |->
      passQ >= 2'h2)
      else $error("swap write before both reads");
   a_done_read_clear: assert property ( // RULE18
      rdRes0Hs && stQ != ST_FINISH |=> !doneQ)
      else $error("done not cleared by status read");
   a_ids_on_done: assert property ( // RULE17
      stQ == ST_FINISH |=> doneQ &&
      res0W[RES_PROC_LSB +: ID_W] == procW &&
      res0W[RES_CTX_LSB +: ID_W] == ctxW)
      else $error("ids not copied at completion");
   a_ssram_nibble_zero: assert property ( // RULE20
      stQ == ST_COLLECT && rdValidS && opW == OP_READ &&
      locW == LOC_SSRAM |=> resLowQ == 4'h0)
      else $error("memory read left data nibble");
endmodule
`default_nettype wire

// >>> verification/lce_engine_model.sv
// behavioural search engine chip, answers reads four cycles later
`timescale 1ns/100ps
`default_nettype none
module lce_engine_model
(
   input wire logic sys_clk,
   input wire logic engValid,
   input wire logic [2:0] engOp,
   input wire logic [15:0] engAddr,
   output logic engReadValid,
   output logic [67:0] engineReadData
);
   logic [2:0] pend = 3'h0;
   logic [47:0] adr = 48'h0;
   logic rdReq;
   assign rdReq = engValid && engOp == 3'h0;
   initial
   begin
      engReadValid = 1'b0;
      engineReadData = 68'h0;
   end
   // outside a return the line flips, so stale data never looks valid;
   // addresses ride with the request flags, so bursts come back in order
   always @(posedge sys_clk)
   begin
      pend <= {pend[1:0], rdReq};
      adr <= {adr[31:0], engAddr};
      engReadValid <= pend[2];
      engineReadData <= pend[2] ? {adr[47:32], 48'hA5A5_0000_1234, 4'hC} :
         ~engineReadData;
   end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the lookup command executor
`timescale 1ns/100ps
`default_nettype none
module tb;
   import lce_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tableFullFlag = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, engValid, engReadValid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [2:0] engOp;
   logic [15:0] engAddr;
   logic [67:0] engDq, engineReadData;
   logic [67:0] beats[$];
   int failures = 0, checks_done = 0, cycles = 0;
   localparam logic [51:0] FILL = 52'hA5A5_0000_1234_C;
   always #5 sys_clk = ~sys_clk;
   lce_executor dut (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .engValid, .engOp,
      .engLoc(), .engSelectId(), .engAddr, .engDq, .engReadValid,
      .engineReadData, .tableFullFlag);
   lce_engine_model eng (.sys_clk, .engValid, .engOp, .engAddr,
      .engReadValid, .engineReadData);
   always @(posedge sys_clk)
      if (engValid === 1'b1)
         beats.push_back(engDq);
   task automatic test_done();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         failures++;
         test_done();
      end
   end
   task automatic cmp(input string n, input logic [67:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // each valid drops at the rising edge that takes it
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         resp = s_axi_bresp;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         d = s_axi_rdata;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   function automatic logic [63:0] dw(input int k);
      return 64'h0123_4567_89AB_CDE0 | 64'(k);
   endfunction
   // start goes in last; polling the status word also clears done
   task automatic run(input logic [31:0] c, output logic [31:0] s);
      beats.delete();
      wr(6'h00, c);
      s = 32'h0;
      for (int i = 0; i < 50 && s[31] !== 1'b1; i++)
         rd(6'h28, s);
   endtask
   task automatic t_search();
      logic [31:0] s;
      int n;
      for (int z = 0; z < 4; z++)
      begin
         n = z == 3 ? 0 : (z == 2 ? 4 : 2);
         run(32'h8043_2102 | (z << 25), s);
         cmp("beats", 68'(n), 68'(beats.size()));
         cmp("size error", 68'(z == 3), 68'(s[29]));
         for (int b = 0; b < n; b++)
            cmp("key", {dw(z ? b : 0), 4'(z ? b + 1 : 1)}, beats[b]);
         rd(6'h28, s);
         cmp("done cleared", 68'h0, 68'(s[31]));
      end
      $display("search test done");
   endtask
   task automatic t_write();
      logic [31:0] s;
      run(32'h8000_5001, s);
      cmp("write beat", {dw(1), 4'h5}, beats[0]);
      cmp("write status", 68'h8B00_0000, 68'(s));
      rd(6'h30, s);
      cmp("write data", 68'h0, 68'(s));
      $display("write test done");
   endtask
   task automatic t_read();
      logic [31:0] s;
      wr(6'h08, 32'h0018_0042);
      run(32'h8000_0000, s);
      cmp("status lo", 68'h8B00_000C, 68'(s));
      rd(6'h2C, s);
      cmp("status hi", 68'h15, 68'(s));
      rd(6'h30, s);
      cmp("data lo", 68'h1234, 68'(s));
      rd(6'h34, s);
      cmp("data hi", 68'h0042_A5A5, 68'(s));
      run(32'h9000_0000, s);
      cmp("memory status", 68'h8B00_0000, 68'(s));
      rd(6'h30, s);
      cmp("memory data", 68'h0001_234C, 68'(s));
      $display("read test done");
   endtask
   task automatic t_learn();
      logic [31:0] s;
      tableFullFlag <= 1'b1;
      run(32'h8000_0003, s);
      cmp("learn error", 68'h1, 68'(s[29]));
      cmp("learn beats", 68'h0, 68'(beats.size()));
      rd(6'h38, s);
      cmp("learn flag", 68'h1, 68'(s[0]));
      tableFullFlag <= 1'b0;
      wr(6'h3C, 32'h1);
      cmp("unmapped", 68'(AXI_SLVERR), 68'(resp));
      $display("learn test done");
   endtask
   // same chip, four entries: move then swap of 0x10.. and 0x20..
   task automatic t_block();
      logic [31:0] s;
      wr(6'h08, 32'h2018_0010);
      wr(6'h0C, 32'h0004_1800);
      for (int m = 0; m < 2; m++)
      begin
         run(32'h8000_0004 + m, s);
         cmp("bursts", 68'(8 + 8 * m), 68'(beats.size()));
         for (int b = 0; b < 4; b++)
         begin
            cmp("to b", {16'(16 + b), FILL}, beats[4 + 8 * m + b]);
            if (m)
               cmp("to a", {16'(32 + b), FILL}, beats[8 + b]);
         end
      end
      $display("block test done");
   endtask
   initial
   begin
      logic [63:0] w;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      wr(6'h04, 32'h0000_0B15);
      for (int k = 0; k < 8; k++)
      begin
         w = dw(k / 2);
         wr(6'(8 + 4 * k), k[0] ? w[63:32] : w[31:0]);
      end
      t_search();
      t_write();
      t_read();
      t_learn();
      t_block();
      test_done();
   end
endmodule
`default_nettype wire
